// [hw/mode_and_gpio_config_regs.sv]
`timescale 1ns/100ps
`default_nettype none
module mode_and_gpio_config_regs #(
	parameter int NUM_CH = 8
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register port from the serial frame decoder
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rdata_valid,
	// From general configuration and CRC checker
	input wire logic force_analog_all,
	input wire logic crc_enable,
	input wire logic inbound_crc_error_flag,
	// To CRC logic
	output logic crc_check_active,
	// To sequencer and timing
	output logic [1:0] conversion_mode_select,
	output logic autonomous_active,
	output logic turbo_active,
	output logic oscillator_choice,
	output logic [3:0] sample_divider,
	output logic sequencing_pause,
	output logic seq_start,
	output logic [1:0] seq_mode,
	// Channel pads
	input wire logic [NUM_CH-1:0] analog_channel_pin,
	output logic [NUM_CH-1:0] pin_out,
	output logic [NUM_CH-1:0] pin_oe,
	output logic [NUM_CH-1:0] pin_analog_sel
);
	logic [7:0] operating_mode_config;
	logic [7:0] channel_kind_select;
	logic [7:0] digital_direction_select;
	logic [7:0] output_drive_type;
	logic [7:0] output_level;
	logic [7:0] input_level_readback;
	logic [7:0] scan_sequence_config;
	logic [NUM_CH-1:0] pin_meta;
	logic [NUM_CH-1:0] pin_sync;
	logic crc_fault;
	logic halt_mode;
	logic [NUM_CH-1:0] digital;
	mode_cfg_pkg::halt_state_type halt_state;
	mode_cfg_pkg::halt_state_type next_halt_state;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			operating_mode_config <= mode_cfg_pkg::RESET_VALUE;
			channel_kind_select <= mode_cfg_pkg::RESET_VALUE;
			digital_direction_select <= mode_cfg_pkg::RESET_VALUE;
			output_drive_type <= mode_cfg_pkg::RESET_VALUE;
			output_level <= mode_cfg_pkg::RESET_VALUE;
			scan_sequence_config <= mode_cfg_pkg::RESET_VALUE;
		end else if (reg_wr_en) begin
			if (hit(reg_addr, mode_cfg_pkg::ADDR_OPERATING_MODE)) begin
				operating_mode_config <= reg_wdata;
			end
			if (hit(reg_addr, mode_cfg_pkg::ADDR_CHANNEL_KIND)) begin
				channel_kind_select <= reg_wdata;
			end
			if (hit(reg_addr, mode_cfg_pkg::ADDR_DIGITAL_DIRECTION)) begin
				digital_direction_select <= reg_wdata;
			end
			if (hit(reg_addr, mode_cfg_pkg::ADDR_OUTPUT_DRIVE_TYPE)) begin
				output_drive_type <= reg_wdata;
			end
			if (hit(reg_addr, mode_cfg_pkg::ADDR_OUTPUT_LEVEL)) begin
				output_level <= reg_wdata;
			end
			if (hit(reg_addr, mode_cfg_pkg::ADDR_SCAN_SEQUENCE)) begin
				scan_sequence_config <= reg_wdata &
					mode_cfg_pkg::SCAN_SEQUENCE_MASK;
			end
		end
	end

	// Read answer one cycle after the strobe; unmapped reads zero
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			reg_rdata <= mode_cfg_pkg::RESET_VALUE;
			reg_rdata_valid <= 1'b0;
		end else begin
			reg_rdata_valid <= reg_rd_en;
			if (!reg_rd_en) begin
				reg_rdata <= mode_cfg_pkg::RESET_VALUE;
			end else if (hit(reg_addr, mode_cfg_pkg::ADDR_OPERATING_MODE)) begin
				reg_rdata <= operating_mode_config;
			end else if (hit(reg_addr, mode_cfg_pkg::ADDR_CHANNEL_KIND)) begin
				reg_rdata <= channel_kind_select;
			end else if (hit(reg_addr,
				mode_cfg_pkg::ADDR_DIGITAL_DIRECTION)) begin
				reg_rdata <= digital_direction_select;
			end else if (hit(reg_addr,
				mode_cfg_pkg::ADDR_OUTPUT_DRIVE_TYPE)) begin
				reg_rdata <= output_drive_type;
			end else if (hit(reg_addr, mode_cfg_pkg::ADDR_OUTPUT_LEVEL)) begin
				reg_rdata <= output_level;
			end else if (hit(reg_addr, mode_cfg_pkg::ADDR_INPUT_LEVEL)) begin
				reg_rdata <= input_level_readback;
			end else if (hit(reg_addr, mode_cfg_pkg::ADDR_SCAN_SEQUENCE)) begin
				reg_rdata <= scan_sequence_config;
			end else begin
				reg_rdata <= mode_cfg_pkg::UNMAPPED_READ;
			end
		end
	end

	// Pads are asynchronous to core_clk
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pin_meta <= '0;
			pin_sync <= '0;
			input_level_readback <= mode_cfg_pkg::RESET_VALUE;
		end else begin
			pin_meta <= analog_channel_pin;
			pin_sync <= pin_meta;
			input_level_readback <= 8'(pin_sync);
		end
	end

	assign crc_fault = crc_enable & inbound_crc_error_flag;
	assign halt_mode = operating_mode_config[
		mode_cfg_pkg::HALT_ON_CRC_FAULT_BIT] &&
		(autonomous_active || turbo_active);

	always_comb begin
		next_halt_state = halt_state;
		unique case (halt_state)
			mode_cfg_pkg::SEQ_RUN: begin
				if (halt_mode && crc_fault) begin
					next_halt_state = mode_cfg_pkg::SEQ_HALTED;
				end
			end
			mode_cfg_pkg::SEQ_HALTED: begin
				if (!crc_fault) begin
					next_halt_state = mode_cfg_pkg::SEQ_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			halt_state <= mode_cfg_pkg::SEQ_RUN;
			sequencing_pause <= 1'b0;
		end else begin
			halt_state <= next_halt_state;
			sequencing_pause <= (next_halt_state == mode_cfg_pkg::SEQ_HALTED);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			conversion_mode_select <= mode_cfg_pkg::MODE_HOST_STARTED;
			autonomous_active <= 1'b0;
			turbo_active <= 1'b0;
			oscillator_choice <= 1'b0;
			sample_divider <= 4'h0;
			crc_check_active <= 1'b0;
			seq_start <= 1'b0;
			seq_mode <= 2'h0;
		end else begin
			conversion_mode_select <= operating_mode_config[
				mode_cfg_pkg::CONVERSION_MODE_SELECT_MSB:mode_cfg_pkg::CONVERSION_MODE_SELECT_LSB];
			autonomous_active <= operating_mode_config[
				mode_cfg_pkg::CONVERSION_MODE_SELECT_MSB:mode_cfg_pkg::CONVERSION_MODE_SELECT_LSB]
				== mode_cfg_pkg::MODE_AUTONOMOUS;
			turbo_active <= operating_mode_config[
				mode_cfg_pkg::CONVERSION_MODE_SELECT_MSB:mode_cfg_pkg::CONVERSION_MODE_SELECT_LSB]
				== mode_cfg_pkg::MODE_TURBO;
			oscillator_choice <=
				operating_mode_config[mode_cfg_pkg::OSC_CHOICE_BIT];
			sample_divider <= operating_mode_config[
				mode_cfg_pkg::DIVIDER_MSB:mode_cfg_pkg::DIVIDER_LSB];
			crc_check_active <= crc_enable;
			seq_start <= scan_sequence_config[mode_cfg_pkg::SEQ_START_BIT];
			seq_mode <= scan_sequence_config[
				mode_cfg_pkg::SEQ_MODE_MSB:mode_cfg_pkg::SEQ_MODE_LSB];
		end
	end

	// kind with overrides
	// Registers stay untouched during a halt, so release restores them
	assign digital = channel_kind_select[NUM_CH-1:0] &
		{NUM_CH{~force_analog_all && halt_state == mode_cfg_pkg::SEQ_RUN}};

	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_pin
		channel_pin_slice u_slice (
			.core_clk(core_clk),
			.rst_n(rst_n),
			.digital(digital[ch]),
			.direction_out(digital_direction_select[ch]),
			.push_pull(output_drive_type[ch]),
			.level(output_level[ch]),
			.pin_out(pin_out[ch]),
			.pin_oe(pin_oe[ch]),
			.analog_sel(pin_analog_sel[ch])
		);
	end

	sequence s_fault_seen;
		halt_mode && crc_fault && !sequencing_pause;
	endsequence
	sequence s_halted_all_analog;
		sequencing_pause ##1 (&pin_analog_sel && pin_oe == '0);
	endsequence

	property p_continue_on_fault;
		@(posedge core_clk) disable iff (!rst_n)
		(!halt_mode && !sequencing_pause && crc_fault) |=> !sequencing_pause;
	endproperty
	a_continue_on_fault: assert property (p_continue_on_fault)
		else $error("pause raised with halt disabled");

	property p_halt_on_fault;
		@(posedge core_clk) disable iff (!rst_n)
		s_fault_seen |=> s_halted_all_analog;
	endproperty
	a_halt_on_fault: assert property (p_halt_on_fault)
		else $error("fault did not halt and force analog");

	property p_resume;
		@(posedge core_clk) disable iff (!rst_n)
		(sequencing_pause && !crc_fault) |=> !sequencing_pause ##1
			(pin_analog_sel == ~$past(digital));
	endproperty
	a_resume: assert property (p_resume)
		else $error("no resume after flag clear");

	property p_mode_write;
		@(posedge core_clk) disable iff (!rst_n)
		(reg_wr_en && reg_addr == mode_cfg_pkg::ADDR_OPERATING_MODE) |=> ##1
			(conversion_mode_select == $past(reg_wdata[6:5], 2) &&
			oscillator_choice == $past(reg_wdata[4], 2) &&
			sample_divider == $past(reg_wdata[3:0], 2));
	endproperty
	a_mode_write: assert property (p_mode_write)
		else $error("mode fields not applied");

	property p_turbo;
		@(posedge core_clk) disable iff (!rst_n)
		turbo_active |-> (conversion_mode_select == mode_cfg_pkg::MODE_TURBO
			&& !autonomous_active);
	endproperty
	a_turbo: assert property (p_turbo)
		else $error("turbo decode wrong");

	property p_kind;
		@(posedge core_clk) disable iff (!rst_n)
		(!force_analog_all && !sequencing_pause) |=>
			pin_analog_sel == ~$past(channel_kind_select);
	endproperty
	a_kind: assert property (p_kind)
		else $error("analog select does not follow kind");

	property p_readback;
		@(posedge core_clk) disable iff (!rst_n)
		$past(rst_n, 3) |-> input_level_readback == $past(analog_channel_pin, 3);
	endproperty
	a_readback: assert property (p_readback)
		else $error("readback not three cycles behind pins");

	property p_force_analog;
		@(posedge core_clk) disable iff (!rst_n)
		force_analog_all |=> (&pin_analog_sel && pin_oe == '0);
	endproperty
	a_force_analog: assert property (p_force_analog)
		else $error("force analog not honoured");

	property p_crc_enable;
		@(posedge core_clk) disable iff (!rst_n)
		crc_enable |=> crc_check_active;
	endproperty
	a_crc_enable: assert property (p_crc_enable)
		else $error("crc check not enabled");
endmodule : mode_and_gpio_config_regs
`default_nettype wire

// [shared/mode_cfg_pkg.sv]
`default_nettype none
package mode_cfg_pkg;
	// Register offsets on the serial register port
	localparam logic [7:0] ADDR_OPERATING_MODE = 8'h04;
	localparam logic [7:0] ADDR_CHANNEL_KIND = 8'h05;
	localparam logic [7:0] ADDR_DIGITAL_DIRECTION = 8'h07;
	localparam logic [7:0] ADDR_OUTPUT_DRIVE_TYPE = 8'h09;
	localparam logic [7:0] ADDR_OUTPUT_LEVEL = 8'h0B;
	localparam logic [7:0] ADDR_INPUT_LEVEL = 8'h0D;
	localparam logic [7:0] ADDR_SCAN_SEQUENCE = 8'h10;

	// Reset values
	localparam logic [7:0] RESET_VALUE = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// Operating mode field positions
	localparam int HALT_ON_CRC_FAULT_BIT = 7;
	localparam int CONVERSION_MODE_SELECT_MSB = 6;
	localparam int CONVERSION_MODE_SELECT_LSB = 5;
	localparam int OSC_CHOICE_BIT = 4;
	localparam int DIVIDER_MSB = 3;
	localparam int DIVIDER_LSB = 0;

	// Scan sequence field positions; other bits read zero
	localparam int SEQ_START_BIT = 4;
	localparam int SEQ_MODE_MSB = 1;
	localparam int SEQ_MODE_LSB = 0;
	localparam logic [7:0] SCAN_SEQUENCE_MASK = 8'h13;

	// Conversion mode codes
	localparam logic [1:0] MODE_HOST_STARTED = 2'h0;
	localparam logic [1:0] MODE_AUTONOMOUS = 2'h1;
	localparam logic [1:0] MODE_TURBO = 2'h2;

	// Sequencing state under CRC fault
	typedef enum logic [0:0] {
		SEQ_RUN = 1'b0,
		SEQ_HALTED = 1'b1
	} halt_state_type;
endpackage : mode_cfg_pkg
`default_nettype wire

// [hw/channel_pin_slice.sv]
`timescale 1ns/100ps
`default_nettype none
module channel_pin_slice (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Effective configuration of this channel
	input wire logic digital,
	input wire logic direction_out,
	input wire logic push_pull,
	input wire logic level,
	// Pad controls
	output logic pin_out,
	output logic pin_oe,
	output logic analog_sel
);
	logic drive;

	assign drive = digital & direction_out;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
			analog_sel <= 1'b1;
		end else begin
			analog_sel <= ~digital;
			if (drive && push_pull) begin
				pin_out <= level;
				pin_oe <= 1'b1;
			end else begin
				// Open drain never drives high; pull-up does it
				pin_out <= 1'b0;
				pin_oe <= drive & ~level;
			end
		end
	end

	// Checked per slice so every channel is covered
	property p_input_dir;
		@(posedge core_clk) disable iff (!rst_n)
		!direction_out |=> !pin_oe;
	endproperty
	a_input_dir: assert property (p_input_dir)
		else $error("input channel driven");

	property p_push_pull;
		@(posedge core_clk) disable iff (!rst_n)
		(digital && direction_out && push_pull)
			|=> (pin_oe && pin_out == $past(level));
	endproperty
	a_push_pull: assert property (p_push_pull)
		else $error("push-pull output wrong");

	property p_open_drain;
		@(posedge core_clk) disable iff (!rst_n)
		(digital && direction_out && !push_pull)
			|=> (!pin_out && pin_oe == !$past(level));
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("open-drain output wrong");
endmodule : channel_pin_slice
`default_nettype wire

// [tb/pad_model.sv]
`timescale 1ns/100ps
`default_nettype none
module pad_model (
	// Device side of the pads
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	// Outside world
	input wire logic [7:0] ext_level,
	input wire logic [7:0] ext_en,
	output logic [7:0] pad_level
);
	// Released pads follow ext_level where ext_en is set, else sit at the board pull-up
	assign pad_level = (pin_oe & pin_out) | (~pin_oe & (~ext_en | ext_level));
endmodule : pad_model
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic reg_wr_en = 1'b0;
	logic reg_rd_en = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic force_all = 1'b0;
	logic crc_en = 1'b0;
	logic crc_flag = 1'b0;
	logic [7:0] ext_level = 8'h00;
	logic [7:0] ext_en = 8'h00;
	logic [7:0] pad_level, reg_rdata, pin_out, pin_oe, pin_sel;
	logic rvalid, crc_act, auto_act, turbo_act, osc, pause, seq_start;
	logic [1:0] mode, seq_mode;
	logic [3:0] div;
	logic [7:0] k, d, p, l, v;
	logic [23:0] e;
	logic h;
	int err_total = 0;
	int check_count = 0;

	function automatic logic [7:0] rw_addr(input int i);
		case (i)
			0: return mode_cfg_pkg::ADDR_OPERATING_MODE;
			1: return mode_cfg_pkg::ADDR_CHANNEL_KIND;
			2: return mode_cfg_pkg::ADDR_DIGITAL_DIRECTION;
			3: return mode_cfg_pkg::ADDR_OUTPUT_DRIVE_TYPE;
			default: return mode_cfg_pkg::ADDR_OUTPUT_LEVEL;
		endcase
	endfunction : rw_addr

	always #4 core_clk = ~core_clk;

	mode_and_gpio_config_regs #(.NUM_CH(8)) i_mode_and_gpio_config_regs (
		.core_clk(core_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rdata_valid(rvalid),
		.force_analog_all(force_all), .crc_enable(crc_en),
		.inbound_crc_error_flag(crc_flag), .crc_check_active(crc_act),
		.conversion_mode_select(mode), .autonomous_active(auto_act),
		.turbo_active(turbo_act), .oscillator_choice(osc),
		.sample_divider(div), .sequencing_pause(pause),
		.seq_start(seq_start), .seq_mode(seq_mode),
		.analog_channel_pin(pad_level), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_analog_sel(pin_sel));

	pad_model i_pad_model (.pin_out(pin_out), .pin_oe(pin_oe),
		.ext_level(ext_level), .ext_en(ext_en), .pad_level(pad_level));

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : step

	// Extra edge keeps strobe edges apart
	task automatic wr(input logic [7:0] a, input logic [7:0] dt);
		reg_addr = a;
		reg_wdata = dt;
		reg_wr_en = 1'b1;
		step(1);
		reg_wr_en = 1'b0;
		step(1);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr = a;
		reg_rd_en = 1'b1;
		step(1);
		reg_rd_en = 1'b0;
		chk({rvalid, reg_rdata}, {1'b1, exp});
		step(1);
		chk({rvalid, reg_rdata}, 24'h000000);
	endtask : rd

	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	// Expected {analog select, enable, out}; fh is force or halt
	function automatic logic [23:0] pins(input logic [7:0] k, d, p, l,
		input logic fh);
		logic [7:0] dig;
		logic [7:0] en;
		dig = k & ~{8{fh}};
		en = dig & d;
		return {~dig, en & (p | ~l), en & p & l};
	endfunction : pins

	function automatic logic [7:0] pad(input logic [23:0] e, input logic [7:0] n);
		return (e[15:8] & e[7:0]) | (~e[15:8] & (~n | ext_level));
	endfunction : pad

	task automatic set_pins;
		wr(mode_cfg_pkg::ADDR_CHANNEL_KIND, k);
		wr(mode_cfg_pkg::ADDR_DIGITAL_DIRECTION, d);
		wr(mode_cfg_pkg::ADDR_OUTPUT_DRIVE_TYPE, p);
		wr(mode_cfg_pkg::ADDR_OUTPUT_LEVEL, l);
	endtask : set_pins

	initial begin
		v = 8'($urandom(32'hC517));
		step(12);
		rst_n = 1'b1;
		chk({pin_sel, pin_oe, pin_out}, 24'hFF0000);
		for (int i = 0; i < 5; i++)
			rd(rw_addr(i), mode_cfg_pkg::RESET_VALUE);
		$display("test reset done");
		for (int i = 0; i < 5; i++) begin
			v = 8'($urandom());
			wr(rw_addr(i), v);
			rd(rw_addr(i), v);
		end
		wr(mode_cfg_pkg::ADDR_SCAN_SEQUENCE, 8'hFF);
		rd(mode_cfg_pkg::ADDR_SCAN_SEQUENCE, mode_cfg_pkg::SCAN_SEQUENCE_MASK);
		chk({seq_start, seq_mode}, 24'h000007);
		rd(8'h3F, mode_cfg_pkg::UNMAPPED_READ);
		$display("test access done");
		for (int m = 0; m < 4; m++) begin
			v = {1'b0, 2'(m), 5'($urandom())};
			crc_en = 1'($urandom());
			wr(mode_cfg_pkg::ADDR_OPERATING_MODE, v);
			chk(mode, v[6:5]);
			chk({auto_act, turbo_act}, {v[6:5] == 2'h1, v[6:5] == 2'h2});
			chk(osc, v[4]);
			chk(div, v[3:0]);
			chk(crc_act, crc_en);
		end
		$display("test mode done");
		for (int i = 0; i < 12; i++) begin
			{k, d, p, l} = $urandom();
			ext_level = 8'($urandom());
			ext_en = 8'($urandom());
			force_all = (i % 4 == 3);
			set_pins();
			e = pins(k, d, p, l, force_all);
			chk({pin_sel, pin_oe, pin_out}, e);
			step(4);
			rd(mode_cfg_pkg::ADDR_INPUT_LEVEL, pad(e, ext_en));
		end
		force_all = 1'b0;
		$display("test pins done");
		{k, d, p, l} = 32'hFFFF0F55;
		crc_en = 1'b1;
		set_pins();
		for (int i = 0; i < 6; i++) begin
			h = (i >= 3) && (i % 3 != 0);
			wr(mode_cfg_pkg::ADDR_OPERATING_MODE, {i >= 3, 2'(i % 3), 5'h00});
			crc_flag = 1'b1;
			step(3);
			chk(pause, h);
			chk({pin_sel, pin_oe, pin_out}, pins(k, d, p, l, h));
			crc_flag = 1'b0;
			step(3);
			chk(pause, 1'b0);
			chk({pin_sel, pin_oe, pin_out}, pins(k, d, p, l, 1'b0));
		end
		$display("test halt done");
		finish_test();
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		finish_test();
	end
endmodule : tb
`default_nettype wire
